// >>> rtl/regen_avoidance_freq_comp.sv
// regeneration avoidance: raises the output frequency while the bus voltage is high
// assumes the ramp generator supplies output frequency and ramp state each cycle,
// and the power stage samples bus voltage synchronously to sys_clk
// outputs settle one edge after the inputs that drive them directly, two through the settings or state register
`timescale 1ns/1ps
`default_nettype none

module regen_avoidance_freq_comp #(
   parameter int TIMER_UNIT_CYCLES = regen_avoid_pkg::TIMER_UNIT_CYCLES
) (
   input  wire logic                                 sys_clk,
   input  wire logic                                 reset_n,
   input  wire regen_avoid_pkg::settings_type        settings,
   input  wire logic                                 settingsWrite,
   input  wire logic [regen_avoid_pkg::VOLT_W-1:0]   busVoltage,
   input  wire regen_avoid_pkg::ramp_type            rampState,
   input  wire logic [regen_avoid_pkg::FREQ_W-1:0]   outputFreq,
   output logic [regen_avoid_pkg::FREQ_W-1:0]        compFreq_ff,
   output regen_avoid_pkg::status_type               status_ff
);

   // ----------------------------------------------------------------
   // accepted settings
   // ----------------------------------------------------------------
   function automatic logic gainOk(input logic [regen_avoid_pkg::GAIN_W-1:0] g);
      gainOk = (g <= regen_avoid_pkg::GAIN_MAX);
   endfunction : gainOk

   regen_avoid_pkg::settings_type cfg_ff;
   regen_avoid_pkg::settings_type nxt_cfg;
   logic                          levelOk;
   logic                          limitOk;
   logic                          modeOk;
   logic                          allOk;
   logic                          rejected_ff;
   logic                          nxt_rejected;

   assign levelOk = (settings.avoidanceVoltageLevel >= regen_avoid_pkg::LEVEL_MIN)
                 && (settings.avoidanceVoltageLevel <= regen_avoid_pkg::LEVEL_MAX);
   assign limitOk = (settings.compensationFreqCap <= regen_avoid_pkg::LIMIT_MAX)
                 || (settings.compensationFreqCap == regen_avoid_pkg::LIMIT_NONE);
   assign modeOk  = (settings.avoidanceModeSelect != 2'h3);
   assign allOk   = levelOk && limitOk && modeOk
                 && gainOk(settings.avoidanceVoltageGain)
                 && gainOk(settings.avoidanceFrequencyGain);
   // a rejected write keeps the whole previous set, so no half-applied tuning
   assign nxt_cfg      = (settingsWrite && allOk) ? settings : cfg_ff;
   assign nxt_rejected = settingsWrite ? !allOk : rejected_ff;

   // ----------------------------------------------------------------
   // settings register
   // ----------------------------------------------------------------

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cfg_ff.avoidanceModeSelect     <= regen_avoid_pkg::MODE_OFF;
         cfg_ff.avoidanceVoltageLevel   <= regen_avoid_pkg::LEVEL_INIT;
         cfg_ff.compensationFreqCap     <= regen_avoid_pkg::LIMIT_INIT;
         cfg_ff.avoidanceVoltageGain    <= regen_avoid_pkg::GAIN_INIT;
         cfg_ff.avoidanceFrequencyGain  <= regen_avoid_pkg::GAIN_INIT;
         cfg_ff.maximumFrequencySetting <= regen_avoid_pkg::MAXFREQ_INIT;
         cfg_ff.returnStep              <= '0;
         cfg_ff.ovStallLevel            <= regen_avoid_pkg::LEVEL_MAX;
         cfg_ff.alarmOutputSelection    <= 1'b0;
         cfg_ff.alarmOutputTimer        <= '0;
         rejected_ff                    <= 1'b0;
      end else begin
         cfg_ff      <= nxt_cfg;
         rejected_ff <= nxt_rejected;
      end
   end

   // ----------------------------------------------------------------
   // enable and detection
   // ----------------------------------------------------------------
   logic                                running;
   logic                                enabled;
   logic                                overLevel;
   logic                                noCap;
   logic [regen_avoid_pkg::VOLT_W-1:0]  excess;
   logic [25:0]                         delta;

   assign running   = (rampState != regen_avoid_pkg::RAMP_STOP);
   assign enabled   = ((cfg_ff.avoidanceModeSelect == regen_avoid_pkg::MODE_ALWAYS) && running)
                   || ((cfg_ff.avoidanceModeSelect == regen_avoid_pkg::MODE_CONST)
                       && (rampState == regen_avoid_pkg::RAMP_CONST));
   assign overLevel = enabled && (busVoltage >= cfg_ff.avoidanceVoltageLevel);
   // wraps below the level; only summed while overLevel holds
   assign excess    = busVoltage - cfg_ff.avoidanceVoltageLevel;
   // full scale times both gains still fits the 26-bit product
   // two gains
   assign delta     = excess * cfg_ff.avoidanceVoltageGain * cfg_ff.avoidanceFrequencyGain;
   assign noCap     = (cfg_ff.compensationFreqCap == regen_avoid_pkg::LIMIT_NONE);

   // ----------------------------------------------------------------
   // compensation state machine
   // ----------------------------------------------------------------
   regen_avoid_pkg::avoid_state_type      state_ff;
   regen_avoid_pkg::avoid_state_type      nxt_state;
   logic [regen_avoid_pkg::ACC_W-1:0]     acc_ff;
   logic [regen_avoid_pkg::ACC_W-1:0]     nxt_acc;
   logic [regen_avoid_pkg::FREQ_W-1:0]    base_ff;
   logic [regen_avoid_pkg::FREQ_W-1:0]    nxt_base;
   logic [regen_avoid_pkg::ACC_W:0]       accSum;
   logic [regen_avoid_pkg::FREQ_W-1:0]    offset;
   logic [regen_avoid_pkg::FREQ_W:0]      raised;
   logic [regen_avoid_pkg::FREQ_W:0]      capVal;
   logic                                  overCap;
   logic                                  halfReached;
   logic                                  releaseDone;
   logic                                  decel;

   // ----------------------------------------------------------------
   // frequency arithmetic
   // ----------------------------------------------------------------

   assign accSum  = {1'b0, acc_ff} + {7'h00, delta};
   // integer part of the accumulator, in 0.01 Hz
   assign offset  = acc_ff[regen_avoid_pkg::ACC_W-1:regen_avoid_pkg::FRAC_W];
   assign raised  = {1'b0, outputFreq} + {1'b0, offset};
   assign capVal  = {1'b0, base_ff}
                  + {3'h0, cfg_ff.compensationFreqCap};
   assign decel   = (rampState == regen_avoid_pkg::RAMP_DECEL);
   assign overCap = !noCap && (raised > capVal);
   // doubling the output avoids a divide and keeps odd limits exact
   // release point at half limit
   assign halfReached = ({1'b0, outputFreq, 1'b0} <= {4'h0, cfg_ff.compensationFreqCap});
   // one more step would underflow, so finish at or below one step
   assign releaseDone = (acc_ff <= cfg_ff.returnStep);

   always_comb begin
      nxt_state = state_ff;
      nxt_acc   = acc_ff;
      nxt_base  = base_ff;
      case (state_ff)
         regen_avoid_pkg::AV_IDLE: begin
            nxt_acc = '0;
            if (overLevel) begin
               // base taken on the entry edge, before any raise shows
               // frequency before avoidance
               nxt_base  = outputFreq;
               nxt_state = regen_avoid_pkg::AV_RAISE;
            end
         end
         regen_avoid_pkg::AV_RAISE: begin
            if (!enabled) begin
               nxt_state = regen_avoid_pkg::AV_IDLE;
            end else if (decel && overCap) begin
               nxt_state = regen_avoid_pkg::AV_HOLD;
            end else if (overLevel) begin
               // accumulate raise; saturate rather than wrap
               nxt_acc = accSum[regen_avoid_pkg::ACC_W] ? '1
                       : accSum[regen_avoid_pkg::ACC_W-1:0];
            end else begin
               nxt_state = regen_avoid_pkg::AV_RELEASE;
            end
         end
         regen_avoid_pkg::AV_HOLD: begin
            // accumulator frozen, so release starts from the held offset
            if (!enabled) begin
               nxt_state = regen_avoid_pkg::AV_IDLE;
            end else if (halfReached) begin
               nxt_state = regen_avoid_pkg::AV_RELEASE;
            end
         end
         regen_avoid_pkg::AV_RELEASE: begin
            if (!enabled) begin
               nxt_state = regen_avoid_pkg::AV_IDLE;
            end else if (overLevel) begin
               nxt_state = regen_avoid_pkg::AV_RAISE;
            end else if (releaseDone) begin
               nxt_acc   = '0;
               nxt_state = regen_avoid_pkg::AV_IDLE;
            end else begin
               nxt_acc = acc_ff - cfg_ff.returnStep;
            end
         end
         default: begin
            nxt_state = regen_avoid_pkg::AV_IDLE;
            nxt_acc   = '0;
         end
      endcase
   end

   // ----------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         state_ff <= regen_avoid_pkg::AV_IDLE;
         acc_ff   <= '0;
         base_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         acc_ff   <= nxt_acc;
         base_ff  <= nxt_base;
      end
   end

   // ----------------------------------------------------------------
   // output frequency selection
   // ----------------------------------------------------------------
   logic [regen_avoid_pkg::FREQ_W:0]   capped;
   logic [regen_avoid_pkg::FREQ_W:0]   chosen;
   logic [regen_avoid_pkg::FREQ_W-1:0] nxt_compFreq;
   logic                               compensating;

   // release counts too, so cap and clamp follow the offset down
   assign compensating = (state_ff != regen_avoid_pkg::AV_IDLE);
   assign capped = overCap ? capVal : raised;
   // idle passes the ramp frequency straight through
   assign chosen = (state_ff == regen_avoid_pkg::AV_HOLD) ? capVal
                 : compensating ? capped
                 : {1'b0, outputFreq};
   // clamp at maximum; only compensation is clamped here
   assign nxt_compFreq = (compensating
                          && (chosen > {1'b0, cfg_ff.maximumFrequencySetting}))
                       ? cfg_ff.maximumFrequencySetting
                       : chosen[regen_avoid_pkg::FREQ_W-1:0];

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         compFreq_ff <= '0;
      end else begin
         compFreq_ff <= nxt_compFreq;
      end
   end

   // ----------------------------------------------------------------
   // stall indications and overload alarm
   // ----------------------------------------------------------------
   logic                             avoidActive;
   logic                             freezeStall;
   logic                             ovStallEvent;
   logic [regen_avoid_pkg::TICK_W-1:0] tick_ff;
   logic [regen_avoid_pkg::TICK_W-1:0] nxt_tick;
   logic [regen_avoid_pkg::TMR_W-1:0]  units_ff;
   logic [regen_avoid_pkg::TMR_W-1:0]  nxt_units;
   logic                             tickWrap;
   logic                             timerDone;
   regen_avoid_pkg::status_type      nxt_status;

   assign avoidActive = (state_ff == regen_avoid_pkg::AV_RAISE)
                     || (state_ff == regen_avoid_pkg::AV_HOLD);
   // flag only: the ramp generator does the actual freeze
   // decel-only freeze
   assign freezeStall = decel && !avoidActive && (busVoltage >= cfg_ff.ovStallLevel);
   assign ovStallEvent = avoidActive || freezeStall;

   // ----------------------------------------------------------------
   // alarm timer
   // ----------------------------------------------------------------
   // wrap count is a parameter so a bench can shorten the time base
   assign tickWrap  = (tick_ff == regen_avoid_pkg::TICK_W'(TIMER_UNIT_CYCLES - 1));
   assign timerDone = (units_ff >= cfg_ff.alarmOutputTimer);
   // timer restarts whenever the stall condition drops, so short blips never alarm unless the timer setting is zero
   assign nxt_tick  = (!ovStallEvent || tickWrap) ? '0 : tick_ff + 1'b1;
   assign nxt_units = !ovStallEvent ? '0
                    : (tickWrap && !timerDone) ? units_ff + 1'b1 : units_ff;

   // ----------------------------------------------------------------
   // status register
   // ----------------------------------------------------------------

   always_comb begin
      nxt_status = '0;
      nxt_status.compActive          = avoidActive;
      nxt_status.overvoltageStallInd = ovStallEvent;
      nxt_status.stallPrevention     = avoidActive;
      nxt_status.freqFreeze          = freezeStall;
      nxt_status.overloadAlarmOutput = ovStallEvent && cfg_ff.alarmOutputSelection
                                    && timerDone;
      nxt_status.settingRejected     = rejected_ff;
   end

   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         tick_ff   <= '0;
         units_ff  <= '0;
         status_ff <= '0;
      end else begin
         tick_ff   <= nxt_tick;
         units_ff  <= nxt_units;
         status_ff <= nxt_status;
      end
   end

endmodule : regen_avoidance_freq_comp

`default_nettype wire

// >>> shared/regen_avoid_pkg.sv
// constants, carrier types and state codes for the regeneration avoidance block
// assumes one drive control clock at 200 MHz and a synchronous active-low reset
package regen_avoid_pkg;

   // ----------------------------------------------------------------
   // widths
   // ----------------------------------------------------------------
   localparam int FREQ_W  = 16;   // output frequency, 0.01 Hz per lsb
   localparam int VOLT_W  = 10;   // bus voltage, 1 V per lsb
   localparam int LIMIT_W = 14;   // cap setting, 0.01 Hz per lsb
   localparam int GAIN_W  = 8;    // percent
   localparam int ACC_W   = 32;
   localparam int FRAC_W  = 16;   // fraction bits of the compensation accumulator
   localparam int TMR_W   = 8;    // alarm timer, 0.1 s per lsb

   // ----------------------------------------------------------------
   // setting ranges and reset values
   // ----------------------------------------------------------------
   localparam logic [1:0]         MODE_OFF      = 2'h0;
   localparam logic [1:0]         MODE_ALWAYS   = 2'h1;
   localparam logic [1:0]         MODE_CONST    = 2'h2;
   localparam logic [VOLT_W-1:0]  LEVEL_MIN     = 10'h12C;  // 300 V
   localparam logic [VOLT_W-1:0]  LEVEL_MAX     = 10'h320;  // 800 V
   localparam logic [VOLT_W-1:0]  LEVEL_INIT    = 10'h186;  // plain default, 390 V
   localparam logic [LIMIT_W-1:0] LIMIT_MAX     = 14'h03E8; // 10.00 Hz
   localparam logic [LIMIT_W-1:0] LIMIT_NONE    = 14'h270F; // 9999
   localparam logic [LIMIT_W-1:0] LIMIT_INIT    = 14'h0258; // 6.00 Hz
   localparam logic [GAIN_W-1:0]  GAIN_MAX      = 8'hC8;    // 200 %
   localparam logic [GAIN_W-1:0]  GAIN_INIT     = 8'h64;    // 100 %
   localparam logic [FREQ_W-1:0]  MAXFREQ_INIT  = 16'h2EE0; // plain default, 120 Hz

   // ----------------------------------------------------------------
   // alarm timer time base
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS     = 5;
   localparam int TIMER_UNIT_US     = 100000;  // 0.1 s per timer step
   localparam int TIMER_UNIT_CYCLES = TIMER_UNIT_US * 1000 / CLK_PERIOD_NS;
   localparam int TICK_W            = 25;

   typedef enum logic [1:0] {
      RAMP_STOP  = 2'b00,
      RAMP_ACCEL = 2'b01,
      RAMP_CONST = 2'b10,
      RAMP_DECEL = 2'b11
   } ramp_type;

   typedef enum logic [1:0] {
      AV_IDLE    = 2'b00,
      AV_RAISE   = 2'b01,
      AV_HOLD    = 2'b10,
      AV_RELEASE = 2'b11
   } avoid_state_type;

   typedef struct packed {
      logic [1:0]         avoidanceModeSelect;
      logic [VOLT_W-1:0]  avoidanceVoltageLevel;
      logic [LIMIT_W-1:0] compensationFreqCap;
      logic [GAIN_W-1:0]  avoidanceVoltageGain;
      logic [GAIN_W-1:0]  avoidanceFrequencyGain;
      logic [FREQ_W-1:0]  maximumFrequencySetting;
      logic [ACC_W-1:0]   returnStep;          // accumulator units per cycle
      logic [VOLT_W-1:0]  ovStallLevel;
      logic               alarmOutputSelection; // overvoltage stall drives alarm
      logic [TMR_W-1:0]   alarmOutputTimer;
   } settings_type;

   typedef struct packed {
      logic compActive;
      logic overvoltageStallInd;
      logic stallPrevention;
      logic freqFreeze;
      logic overloadAlarmOutput;
      logic settingRejected;
   } status_type;

endpackage : regen_avoid_pkg

// >>> tb/regen_avoidance_freq_comp_chk.sv
// checker: port-level assertions for the regeneration avoidance block
// assumes binding into the design top; settings tracked from accepted writes
`timescale 1ns/1ps
`default_nettype none
module regen_avoidance_freq_comp_chk #(
   parameter int TIMER_UNIT_CYCLES = regen_avoid_pkg::TIMER_UNIT_CYCLES
) (
   input wire logic                               sys_clk,
   input wire logic                               reset_n,
   input wire regen_avoid_pkg::settings_type      settings,
   input wire logic                               settingsWrite,
   input wire logic [regen_avoid_pkg::VOLT_W-1:0] busVoltage,
   input wire regen_avoid_pkg::ramp_type          rampState,
   input wire logic [regen_avoid_pkg::FREQ_W-1:0] outputFreq,
   input wire logic [regen_avoid_pkg::FREQ_W-1:0] compFreq_ff,
   input wire regen_avoid_pkg::status_type        status_ff
);
   regen_avoid_pkg::settings_type cfg_ff;
   logic [2:0]                    quiet_ff;
   // writes take two edges to show; assertions wait until things settle
   wire settled = quiet_ff == 3'h7;
   wire wrOk = settings.avoidanceModeSelect != 2'h3
      && settings.avoidanceVoltageLevel >= regen_avoid_pkg::LEVEL_MIN
      && settings.avoidanceVoltageLevel <= regen_avoid_pkg::LEVEL_MAX
      && (settings.compensationFreqCap <= regen_avoid_pkg::LIMIT_MAX
          || settings.compensationFreqCap == regen_avoid_pkg::LIMIT_NONE)
      && settings.avoidanceVoltageGain <= regen_avoid_pkg::GAIN_MAX
      && settings.avoidanceFrequencyGain <= regen_avoid_pkg::GAIN_MAX;
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         cfg_ff <= '0;
         cfg_ff.avoidanceVoltageLevel <= regen_avoid_pkg::LEVEL_INIT;
         cfg_ff.maximumFrequencySetting <= regen_avoid_pkg::MAXFREQ_INIT;
         quiet_ff <= 3'h7;
      end else begin
         quiet_ff <= settingsWrite ? 3'h0 : quiet_ff + 3'(quiet_ff != 3'h7);
         if (settingsWrite && wrOk) cfg_ff <= settings;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!reset_n);
   property p_ind;
      status_ff.compActive |-> status_ff.overvoltageStallInd && status_ff.stallPrevention;
   endproperty
   a_ind: assert property (p_ind) else $error("stall flags missing");
   property p_off;
      settled && cfg_ff.avoidanceModeSelect == 2'h0 |-> !status_ff.compActive;
   endproperty
   a_off: assert property (p_off) else $error("active while off");
   property p_const;
      (settled && cfg_ff.avoidanceModeSelect == 2'h2 && rampState != regen_avoid_pkg::RAMP_CONST)[*3]
         |-> !status_ff.compActive;
   endproperty
   a_const: assert property (p_const) else $error("active off constant speed");
   property p_raise;
      (settled && cfg_ff.avoidanceModeSelect == 2'h1 && rampState == regen_avoid_pkg::RAMP_ACCEL
         && busVoltage >= cfg_ff.avoidanceVoltageLevel)[*3] |-> status_ff.compActive;
   endproperty
   a_raise: assert property (p_raise) else $error("no avoidance at high bus");
   property p_max;
      settled && status_ff.compActive |-> compFreq_ff <= cfg_ff.maximumFrequencySetting;
   endproperty
   a_max: assert property (p_max) else $error("above maximum frequency");
   property p_rej;
      settingsWrite |-> ##2 status_ff.settingRejected == !$past(wrOk, 2);
   endproperty
   a_rej: assert property (p_rej) else $error("wrong refusal flag");
   property p_frz;
      status_ff.freqFreeze |-> $past(rampState) == regen_avoid_pkg::RAMP_DECEL;
   endproperty
   a_frz: assert property (p_frz) else $error("freeze outside decel");
   property p_alarm;
      (settled && cfg_ff.alarmOutputSelection && cfg_ff.alarmOutputTimer == 8'h00
         && status_ff.compActive)[*3] |-> status_ff.overloadAlarmOutput;
   endproperty
   a_alarm: assert property (p_alarm) else $error("alarm missing");
endmodule : regen_avoidance_freq_comp_chk
bind regen_avoidance_freq_comp regen_avoidance_freq_comp_chk #(
   .TIMER_UNIT_CYCLES(TIMER_UNIT_CYCLES)
) u_chk (.sys_clk, .reset_n, .settings, .settingsWrite, .busVoltage, .rampState,
         .outputFreq, .compFreq_ff, .status_ff);
`default_nettype wire

// >>> tb/drive_stage_model.sv
// far side: dc bus measurement and ramp generator output
// assumes bench commands; slow mode drifts the bus 1 V per cycle
`timescale 1ns/1ps
`default_nettype none
module drive_stage_model (
   input  wire logic                      sys_clk,
   input  wire logic                      reset_n,
   input  wire logic [9:0]                voltTarget,
   input  wire logic                      slow,
   input  wire regen_avoid_pkg::ramp_type rampCmd,
   input  wire logic                      freqLoad,
   input  wire logic [15:0]               freqStart,
   output logic [9:0]                     busVoltage,
   output regen_avoid_pkg::ramp_type      rampState,
   output logic [15:0]                    outputFreq
);
   wire logic [9:0] nxtVolt = !slow ? voltTarget : busVoltage
      + 10'(busVoltage < voltTarget) - 10'(busVoltage > voltTarget);
   always_ff @(posedge sys_clk) begin
      if (!reset_n) begin
         busVoltage <= 10'h0FA;
         rampState  <= regen_avoid_pkg::RAMP_STOP;
         outputFreq <= 16'h0000;
      end else begin
         busVoltage <= nxtVolt;
         rampState  <= rampCmd;
         if (freqLoad) outputFreq <= freqStart;
         else if (rampCmd == regen_avoid_pkg::RAMP_DECEL && outputFreq > 16'h0001)
            outputFreq <= outputFreq - 16'h0002;
      end
   end
endmodule : drive_stage_model
`default_nettype wire

// >>> tb/test_regen_avoidance_freq_comp.sv
// testbench: random and corner scenarios for the avoidance block
// assumes the checker is bound into the design; timer base shortened
`timescale 1ns/1ps
`default_nettype none
module test_regen_avoidance_freq_comp;
   logic                          sys_clk, reset_n, settingsWrite, slow, freqLoad;
   regen_avoid_pkg::settings_type settings, cfg, bad;
   regen_avoid_pkg::ramp_type     rampCmd, rampState;
   regen_avoid_pkg::status_type   status_ff;
   logic [9:0]                    voltTarget, busVoltage;
   logic [15:0]                   freqStart, outputFreq, compFreq_ff, fq, cp;
   int                            num_errors, n_checks;
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("[FAIL] %0t got %0h exp %0h", $time, a, b); end end
   regen_avoidance_freq_comp #(.TIMER_UNIT_CYCLES(4)) dut (.sys_clk, .reset_n, .settings,
      .settingsWrite, .busVoltage, .rampState, .outputFreq, .compFreq_ff, .status_ff);
   drive_stage_model u_far (.sys_clk, .reset_n, .voltTarget, .slow, .rampCmd, .freqLoad,
      .freqStart, .busVoltage, .rampState, .outputFreq);
   function automatic logic [15:0] expFreq(input logic [15:0] f, c, m);
      logic [16:0] s;
      s = (c == 16'(regen_avoid_pkg::LIMIT_NONE)) ? 17'h1FFFF : 17'(f) + 17'(c);
      return (s > 17'(m)) ? m : s[15:0];
   endfunction : expFreq
   task automatic wr(input regen_avoid_pkg::settings_type s, input logic rej);
      @(posedge sys_clk);
      settings      <= s;
      settingsWrite <= 1'b1;
      @(posedge sys_clk);
      settingsWrite <= 1'b0;
      repeat (2) @(posedge sys_clk);
      #1 `CHK(status_ff.settingRejected, rej)
   endtask : wr
   task automatic go(input regen_avoid_pkg::ramp_type r, input logic [15:0] f);
      @(posedge sys_clk);
      rampCmd   <= r;
      freqStart <= f;
      freqLoad  <= 1'b1;
      @(posedge sys_clk);
      freqLoad  <= 1'b0;
   endtask : go
   task automatic setv(input logic [9:0] v, input logic s, input int n);
      @(posedge sys_clk);
      voltTarget <= v;
      slow       <= s;
      repeat (n) @(posedge sys_clk);
   endtask : setv
   task automatic conclude();
      $display("checks %0d errors %0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask : conclude
   initial begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // whole run is some 3000 cycles
   initial begin
      #(5 * 30000);
      num_errors++;
      conclude();
   end
   initial begin
      {reset_n, settingsWrite, slow, freqLoad} = 4'h0;
      {settings, voltTarget, freqStart} = '0;
      rampCmd = regen_avoid_pkg::RAMP_STOP;
      cfg = '0;
      cfg.avoidanceVoltageLevel   = regen_avoid_pkg::LEVEL_MIN;
      cfg.avoidanceVoltageGain    = regen_avoid_pkg::GAIN_INIT;
      cfg.avoidanceFrequencyGain  = regen_avoid_pkg::GAIN_INIT;
      cfg.returnStep              = 32'h0100_0000;
      cfg.ovStallLevel            = 10'h15E;
      cfg.alarmOutputSelection    = 1'b1;
      void'($urandom(81437));
      repeat (10) @(posedge sys_clk);
      reset_n <= 1'b1;
      go(regen_avoid_pkg::RAMP_ACCEL, 16'h03E8);
      setv(10'h190, 1'b0, 30);
      #1 `CHK(status_ff, 6'h00)
      `CHK(compFreq_ff, 16'h03E8)
      for (int i = 0; i < 4; i++) begin
         bad = cfg;
         case (i)
            0: bad.avoidanceModeSelect = 2'h3;
            1: bad.avoidanceVoltageLevel = 10'h12B;
            2: bad.compensationFreqCap = 14'h03E9;
            default: bad.avoidanceFrequencyGain = 8'hC9;
         endcase
         wr(bad, 1'b1);
      end
      cfg.avoidanceModeSelect = regen_avoid_pkg::MODE_ALWAYS;
      for (int i = 0; i < 5; i++) begin
         fq = 16'(100 + $urandom % 5000);
         cfg.compensationFreqCap = (i == 0) ? regen_avoid_pkg::LIMIT_NONE : (i == 1) ? 14'h0
            : (i == 2) ? regen_avoid_pkg::LIMIT_MAX : 14'($urandom % 1001);
         cfg.maximumFrequencySetting = (i == 0) ? fq + 16'h012C : regen_avoid_pkg::MAXFREQ_INIT;
         cfg.avoidanceFrequencyGain = (i == 4) ? 8'h00 : regen_avoid_pkg::GAIN_INIT;
         cp = (i == 4) ? 16'h0000 : 16'(cfg.compensationFreqCap);
         wr(cfg, 1'b0);
         go(regen_avoid_pkg::RAMP_ACCEL, fq);
         setv(10'h190, 1'($urandom), 200);
         #1 `CHK(compFreq_ff, expFreq(fq, cp, cfg.maximumFrequencySetting))
         `CHK(status_ff[5:1], 5'h1D)
         setv(10'h0FA, 1'($urandom), 300);
         #1 `CHK(status_ff.compActive, 1'b0)
         `CHK(compFreq_ff, fq)
      end
      cfg.avoidanceFrequencyGain = regen_avoid_pkg::GAIN_INIT;
      cfg.avoidanceModeSelect = regen_avoid_pkg::MODE_CONST;
      wr(cfg, 1'b0);
      setv(10'h190, 1'b0, 30);
      #1 `CHK(status_ff.compActive, 1'b0)
      go(regen_avoid_pkg::RAMP_CONST, 16'h07D0);
      setv(10'h190, 1'b0, 20);
      #1 `CHK(status_ff.compActive, 1'b1)
      setv(10'h0FA, 1'b0, 40);
      cfg.avoidanceModeSelect = regen_avoid_pkg::MODE_ALWAYS;
      cfg.compensationFreqCap = regen_avoid_pkg::LIMIT_INIT;
      wr(cfg, 1'b0);
      setv(10'h190, 1'b0, 80);
      #1 `CHK(compFreq_ff, 16'h0A28)
      // held cap while the ramp falls, output still above half the limit
      go(regen_avoid_pkg::RAMP_DECEL, 16'h07D0);
      setv(10'h190, 1'b0, 100);
      #1 `CHK(compFreq_ff, 16'h0A28)
      cfg.avoidanceModeSelect = regen_avoid_pkg::MODE_OFF;
      cfg.alarmOutputTimer    = 8'h03;
      wr(cfg, 1'b0);
      go(regen_avoid_pkg::RAMP_DECEL, 16'h07D0);
      setv(10'h190, 1'b0, 5);
      #1 `CHK(status_ff.freqFreeze, 1'b1)
      `CHK(status_ff.compActive, 1'b0)
      go(regen_avoid_pkg::RAMP_ACCEL, 16'h07D0);
      setv(10'h190, 1'b0, 5);
      #1 `CHK(status_ff.freqFreeze, 1'b0)
      // alarm waits three timer units of four cycles after the stall starts
      go(regen_avoid_pkg::RAMP_DECEL, 16'h07D0);
      setv(10'h190, 1'b0, 5);
      #1 `CHK(status_ff.overloadAlarmOutput, 1'b0)
      setv(10'h190, 1'b0, 10);
      #1 `CHK(status_ff.overloadAlarmOutput, 1'b1)
      conclude();
   end
endmodule : test_regen_avoidance_freq_comp
`default_nettype wire
